// ===== verilog/atmp_defines.svh
// Constants of the aux test mux and pseudo-random transmit test block.
// Assumes inclusion by bare name from the selector and top design modules.
// Contract
// - Two independent 4-bit selectors, one per aux output, held in analog test config.
// - Code 0001 drives the aux output from its software-written test DAC value.
// - Codes 0010..0111 route correlators, minimum level, I, Q, I with Q through the DAC.
// - Code 1000 places the production-test signal on the aux output.
// - Pseudo-random mode generates a 9-stage or 15-stage sequence as transmit data.
// - Preamble, sync byte, start bit and parity are inserted per the transmit frame register.
`ifndef ATMP_DEFINES_SVH
`define ATMP_DEFINES_SVH

`define ATMP_ADDR_ANALOG_TEST   4'h0
`define ATMP_ADDR_DAC_ONE       4'h1
`define ATMP_ADDR_DAC_TWO       4'h2
`define ATMP_ADDR_PRBS_CTRL     4'h3
`define ATMP_ADDR_TX_FRAME      4'h4
`define ATMP_ADDR_STATUS        4'h5

`define ATMP_AUX_OUT_ONE_SEL_LSB       4
`define ATMP_AUX_OUT_TWO_SEL_LSB       0
`define ATMP_CTRL_ENABLE_BIT    0
`define ATMP_CTRL_LONG_BIT      1
`define ATMP_CTRL_SEND_BIT      2

`define ATMP_RST_BYTE           8'h00
`define ATMP_PRBS9_SEED         9'h1ff
`define ATMP_PRBS15_SEED        15'h7fff
`define ATMP_PRBS9_TAP          4
`define ATMP_PRBS15_TAP         13
`define ATMP_SYNC_BYTE          8'hb2
`define ATMP_DATA_BITS          4'h8
`define ATMP_MAX_PREAMBLE       3'h7

`endif

// ===== verilog/atmp_pkg.sv
// Types of the aux test mux and pseudo-random transmit test block.
// Assumes the defines header is compiled with it.
package atmp_pkg;
  typedef enum logic [3:0] {
    ATMP_SRC_TRISTATE = 4'h0, ATMP_SRC_DAC_REG  = 4'h1, ATMP_SRC_CORR_ONE = 4'h2,
    ATMP_SRC_CORR_TWO = 4'h3, ATMP_SRC_MIN_LVL  = 4'h4, ATMP_SRC_ADC_I    = 4'h5,
    ATMP_SRC_ADC_Q    = 4'h6, ATMP_SRC_ADC_IQ   = 4'h7, ATMP_SRC_PROD     = 4'h8,
    ATMP_SRC_SE_CLK   = 4'h9, ATMP_SRC_HIGH     = 4'ha, ATMP_SRC_LOW      = 4'hb,
    ATMP_SRC_TX_ACT   = 4'hc, ATMP_SRC_RX_ACT   = 4'hd, ATMP_SRC_SUBCAR   = 4'he,
    ATMP_SRC_TST_BIT  = 4'hf
  } atmp_source_t;

  typedef enum logic [4:0] {
    ATMP_ST_IDLE     = 5'b00001,
    ATMP_ST_PREAMBLE = 5'b00010,
    ATMP_ST_SYNC     = 5'b00100,
    ATMP_ST_START    = 5'b01000,
    ATMP_ST_DATA     = 5'b10000
  } atmp_state_t;

  typedef struct packed {
    logic [7:0] correlator_one_signal;
    logic [7:0] correlator_two_signal;
    logic [7:0] minimum_level_signal;
    logic [7:0] adc_i;
    logic [7:0] adc_q;
  } atmp_analog_t;

  typedef struct packed {
    logic production_test;
    logic secure_element_clock;
    logic transmitter_active;
    logic receiver_active;
    logic subcarrier_detected;
    logic test_bus_selected_bit;
  } atmp_digital_t;

  typedef struct packed {
    logic [2:0] preamble_bytes;
    logic       sync_enable;
    logic       start_enable;
    logic       parity_enable;
    logic       parity_odd;
  } atmp_frame_t;
endpackage : atmp_pkg

// ===== verilog/atmp_aux_select.sv
// One aux output selector: routes one of sixteen sources to a pin and DAC.
// Assumes synchronous source inputs; all outputs registered.
`timescale 1ns/1ps
`include "atmp_defines.svh"
module atmp_aux_select
  import atmp_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic [3:0]    aux_source_select,
  input  wire logic [7:0]    test_dac_value,
  input  wire atmp_analog_t  analog_in,
  input  wire atmp_digital_t digital_in,
  output logic               aux_pin_out,
  output logic               aux_pin_oe_n,
  output logic               aux_dac_enable,
  output logic [7:0]         aux_dac_code
);
  logic       pin_reg,  pin_next;
  logic       oe_n_reg, oe_n_next;
  logic       den_reg,  den_next;
  logic [7:0] code_reg, code_next;
  logic [8:0] iq_sum;

  assign iq_sum = {1'b0, analog_in.adc_i} + {1'b0, analog_in.adc_q};

  always_comb begin
    pin_next  = 1'b0;
    oe_n_next = 1'b0;
    den_next  = 1'b0;
    code_next = `ATMP_RST_BYTE;
    case (atmp_source_t'(aux_source_select))
      ATMP_SRC_TRISTATE: oe_n_next = 1'b1;
      ATMP_SRC_DAC_REG:  begin oe_n_next = 1'b1; den_next = 1'b1; code_next = test_dac_value; end
      ATMP_SRC_CORR_ONE: begin
        oe_n_next = 1'b1; den_next = 1'b1; code_next = analog_in.correlator_one_signal;
      end
      ATMP_SRC_CORR_TWO: begin
        oe_n_next = 1'b1; den_next = 1'b1; code_next = analog_in.correlator_two_signal;
      end
      ATMP_SRC_MIN_LVL:  begin
        oe_n_next = 1'b1; den_next = 1'b1; code_next = analog_in.minimum_level_signal;
      end
      ATMP_SRC_ADC_I:    begin oe_n_next = 1'b1; den_next = 1'b1; code_next = analog_in.adc_i; end
      ATMP_SRC_ADC_Q:    begin oe_n_next = 1'b1; den_next = 1'b1; code_next = analog_in.adc_q; end
      ATMP_SRC_ADC_IQ:   begin oe_n_next = 1'b1; den_next = 1'b1; code_next = iq_sum[8:1]; end
      ATMP_SRC_PROD:     pin_next = digital_in.production_test;
      ATMP_SRC_SE_CLK:   pin_next = digital_in.secure_element_clock;
      ATMP_SRC_HIGH:     pin_next = 1'b1;
      ATMP_SRC_LOW:      pin_next = 1'b0;
      ATMP_SRC_TX_ACT:   pin_next = digital_in.transmitter_active;
      ATMP_SRC_RX_ACT:   pin_next = digital_in.receiver_active;
      ATMP_SRC_SUBCAR:   pin_next = digital_in.subcarrier_detected;
      default:           pin_next = digital_in.test_bus_selected_bit;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_reg  <= 1'b0;
      oe_n_reg <= 1'b1;
      den_reg  <= 1'b0;
      code_reg <= `ATMP_RST_BYTE;
    end else begin
      pin_reg  <= pin_next;
      oe_n_reg <= oe_n_next;
      den_reg  <= den_next;
      code_reg <= code_next;
    end
  end

  assign aux_pin_out    = pin_reg;
  assign aux_pin_oe_n   = oe_n_reg;
  assign aux_dac_enable = den_reg;
  assign aux_dac_code   = code_reg;
endmodule : atmp_aux_select

// ===== verilog/atmp_top.sv
// Aux test observation mux pair, register port and pseudo-random transmit test.
// Assumes synchronous inputs, plain register port with read data one cycle later.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "atmp_defines.svh"
module atmp_top
  import atmp_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_write,
  input  wire logic          reg_read,
  output logic [7:0]         reg_rdata,
  input  wire atmp_analog_t  analog_in,
  input  wire atmp_digital_t digital_in,
  output logic               aux_out_one,
  output logic               aux_out_one_oe_n,
  output logic               aux_one_dac_enable,
  output logic [7:0]         aux_one_dac_code,
  output logic               aux_out_two,
  output logic               aux_out_two_oe_n,
  output logic               aux_two_dac_enable,
  output logic [7:0]         aux_two_dac_code,
  output logic               tx_bit,
  output logic               tx_bit_valid
);
  // Register state
  logic [7:0]  analog_test_config_reg, analog_test_config_next;
  logic [7:0]  dac_one_reg, dac_one_next;
  logic [7:0]  dac_two_reg, dac_two_next;
  logic [1:0]  prbs_ctrl_reg, prbs_ctrl_next;
  atmp_frame_t frame_reg, frame_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        send_cmd;

  always_comb begin
    analog_test_config_next = analog_test_config_reg;
    dac_one_next   = dac_one_reg;
    dac_two_next   = dac_two_reg;
    prbs_ctrl_next = prbs_ctrl_reg;
    frame_next     = frame_reg;
    rdata_next     = `ATMP_RST_BYTE;
    send_cmd       = 1'b0;
    if (reg_write) begin
      if (reg_addr == `ATMP_ADDR_ANALOG_TEST) begin
        analog_test_config_next = reg_wdata;
      end else if (reg_addr == `ATMP_ADDR_DAC_ONE) begin
        dac_one_next = reg_wdata;
      end else if (reg_addr == `ATMP_ADDR_DAC_TWO) begin
        dac_two_next = reg_wdata;
      end else if (reg_addr == `ATMP_ADDR_PRBS_CTRL) begin
        prbs_ctrl_next = {reg_wdata[`ATMP_CTRL_LONG_BIT], reg_wdata[`ATMP_CTRL_ENABLE_BIT]};
        send_cmd       = reg_wdata[`ATMP_CTRL_SEND_BIT];
      end else if (reg_addr == `ATMP_ADDR_TX_FRAME) begin
        frame_next = reg_wdata[6:0];
      end
    end
    if (reg_read) begin
      if (reg_addr == `ATMP_ADDR_ANALOG_TEST) begin
        rdata_next = analog_test_config_reg;
      end else if (reg_addr == `ATMP_ADDR_DAC_ONE) begin
        rdata_next = dac_one_reg;
      end else if (reg_addr == `ATMP_ADDR_DAC_TWO) begin
        rdata_next = dac_two_reg;
      end else if (reg_addr == `ATMP_ADDR_PRBS_CTRL) begin
        rdata_next = {6'h00, prbs_ctrl_reg};
      end else if (reg_addr == `ATMP_ADDR_TX_FRAME) begin
        rdata_next = {1'b0, frame_reg};
      end else if (reg_addr == `ATMP_ADDR_STATUS) begin
        rdata_next = {7'h00, tx_bit_valid};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      analog_test_config_reg <= `ATMP_RST_BYTE;
      dac_one_reg   <= `ATMP_RST_BYTE;
      dac_two_reg   <= `ATMP_RST_BYTE;
      prbs_ctrl_reg <= 2'h0;
      frame_reg     <= 7'h00;
      rdata_reg     <= `ATMP_RST_BYTE;
    end else begin
      analog_test_config_reg <= analog_test_config_next;
      dac_one_reg   <= dac_one_next;
      dac_two_reg   <= dac_two_next;
      prbs_ctrl_reg <= prbs_ctrl_next;
      frame_reg     <= frame_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // Two independent selectors
  logic [3:0] sel_vec [2];
  logic [7:0] dac_vec [2];
  logic [1:0] pin_vec, oe_vec, den_vec;
  logic [7:0] code_vec [2];

  assign sel_vec[0] = analog_test_config_reg[`ATMP_AUX_OUT_ONE_SEL_LSB +: 4];
  assign sel_vec[1] = analog_test_config_reg[`ATMP_AUX_OUT_TWO_SEL_LSB +: 4];
  assign dac_vec[0] = dac_one_reg;
  assign dac_vec[1] = dac_two_reg;

  for (genvar g = 0; g < 2; g++) begin : g_aux
    atmp_aux_select u_sel (
      .ref_clk           (ref_clk),
      .rst_n             (rst_n),
      .aux_source_select (sel_vec[g]),
      .test_dac_value    (dac_vec[g]),
      .analog_in         (analog_in),
      .digital_in        (digital_in),
      .aux_pin_out       (pin_vec[g]),
      .aux_pin_oe_n      (oe_vec[g]),
      .aux_dac_enable    (den_vec[g]),
      .aux_dac_code      (code_vec[g])
    );
  end

  assign aux_out_one        = pin_vec[0];
  assign aux_out_one_oe_n   = oe_vec[0];
  assign aux_one_dac_enable = den_vec[0];
  assign aux_one_dac_code   = code_vec[0];
  assign aux_out_two        = pin_vec[1];
  assign aux_out_two_oe_n   = oe_vec[1];
  assign aux_two_dac_enable = den_vec[1];
  assign aux_two_dac_code   = code_vec[1];

  // Framed pseudo-random transmitter
  atmp_state_t state_reg, state_next;
  logic [14:0] lfsr_reg, lfsr_next;
  logic [2:0]  pre_cnt_reg, pre_cnt_next;
  logic [3:0]  bit_cnt_reg, bit_cnt_next;
  logic [7:0]  sync_byte;
  logic        par_reg, par_next;
  logic        tx_reg, tx_next;
  logic        txv_reg, txv_next;
  logic        prbs_bit;

  assign sync_byte = `ATMP_SYNC_BYTE;

  assign prbs_bit = prbs_ctrl_reg[1] ? (lfsr_reg[14] ^ lfsr_reg[`ATMP_PRBS15_TAP])
                                     : (lfsr_reg[8] ^ lfsr_reg[`ATMP_PRBS9_TAP]);

  always_comb begin
    state_next   = state_reg;
    lfsr_next    = lfsr_reg;
    pre_cnt_next = pre_cnt_reg;
    bit_cnt_next = bit_cnt_reg;
    par_next     = par_reg;
    tx_next      = 1'b0;
    txv_next     = 1'b0;
    case (state_reg)
      ATMP_ST_IDLE: begin
        lfsr_next = prbs_ctrl_next[1] ? `ATMP_PRBS15_SEED : {6'h00, `ATMP_PRBS9_SEED};
        if (send_cmd && prbs_ctrl_next[0]) begin
          pre_cnt_next = frame_next.preamble_bytes;
          bit_cnt_next = 4'h0;
          par_next     = 1'b0;
          state_next   = (frame_next.preamble_bytes != 3'h0) ? ATMP_ST_PREAMBLE
                       : frame_next.sync_enable ? ATMP_ST_SYNC
                       : frame_next.start_enable ? ATMP_ST_START : ATMP_ST_DATA;
        end
      end
      ATMP_ST_PREAMBLE: begin
        tx_next      = 1'b0;
        txv_next     = 1'b1;
        bit_cnt_next = bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == `ATMP_DATA_BITS - 4'h1) begin
          bit_cnt_next = 4'h0;
          pre_cnt_next = pre_cnt_reg - 3'h1;
          if (pre_cnt_reg == 3'h1) begin
            state_next = frame_reg.sync_enable ? ATMP_ST_SYNC
                       : frame_reg.start_enable ? ATMP_ST_START : ATMP_ST_DATA;
          end
        end
      end
      ATMP_ST_SYNC: begin
        tx_next      = sync_byte[3'h7 - bit_cnt_reg[2:0]];
        txv_next     = 1'b1;
        bit_cnt_next = bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == `ATMP_DATA_BITS - 4'h1) begin
          bit_cnt_next = 4'h0;
          state_next   = frame_reg.start_enable ? ATMP_ST_START : ATMP_ST_DATA;
        end
      end
      ATMP_ST_START: begin
        tx_next    = 1'b1;
        txv_next   = 1'b1;
        state_next = ATMP_ST_DATA;
      end
      default: begin
        txv_next = 1'b1;
        if (bit_cnt_reg == `ATMP_DATA_BITS) begin
          tx_next      = par_reg ^ frame_reg.parity_odd;
          bit_cnt_next = 4'h0;
          par_next     = 1'b0;
        end else begin
          tx_next      = prbs_bit;
          lfsr_next    = {lfsr_reg[13:0], prbs_bit};
          par_next     = par_reg ^ prbs_bit;
          bit_cnt_next = (bit_cnt_reg == `ATMP_DATA_BITS - 4'h1 && !frame_reg.parity_enable)
                         ? 4'h0 : bit_cnt_reg + 4'h1;
          if (bit_cnt_next == 4'h0) begin
            par_next = 1'b0;
          end
        end
        if (!prbs_ctrl_next[0]) begin
          state_next = ATMP_ST_IDLE;
          txv_next   = 1'b0;
          tx_next    = 1'b0;
        end
      end
    endcase
    if (state_reg != ATMP_ST_IDLE && state_reg != ATMP_ST_DATA && !prbs_ctrl_next[0]) begin
      state_next = ATMP_ST_IDLE;
      txv_next   = 1'b0;
      tx_next    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg   <= ATMP_ST_IDLE;
      lfsr_reg    <= `ATMP_PRBS15_SEED;
      pre_cnt_reg <= 3'h0;
      bit_cnt_reg <= 4'h0;
      par_reg     <= 1'b0;
      tx_reg      <= 1'b0;
      txv_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      lfsr_reg    <= lfsr_next;
      pre_cnt_reg <= pre_cnt_next;
      bit_cnt_reg <= bit_cnt_next;
      par_reg     <= par_next;
      tx_reg      <= tx_next;
      txv_reg     <= txv_next;
    end
  end

  assign tx_bit       = tx_reg;
  assign tx_bit_valid = txv_reg;
endmodule : atmp_top

// ===== tb/atmp_tb_ref.svh
// Reference mapping of one aux selector for the bench and the checker.
// Assumes atmp_pkg is imported where it is included; result is {pin, oe_n, dac_en, code}.
function automatic logic [10:0] atmp_ref(input logic [3:0] s, input logic [7:0] d,
                                         input atmp_analog_t a, input atmp_digital_t g);
  logic [8:0] iq;
  iq = {1'b0, a.adc_i} + {1'b0, a.adc_q};
  case (s)
    4'h0: return 11'h200;
    4'h1: return {3'b011, d};
    4'h2: return {3'b011, a.correlator_one_signal};
    4'h3: return {3'b011, a.correlator_two_signal};
    4'h4: return {3'b011, a.minimum_level_signal};
    4'h5: return {3'b011, a.adc_i};
    4'h6: return {3'b011, a.adc_q};
    4'h7: return {3'b011, iq[8:1]};
    4'h8: return {g.production_test, 10'h000};
    4'h9: return {g.secure_element_clock, 10'h000};
    4'ha: return 11'h400;
    4'hb: return 11'h000;
    4'hc: return {g.transmitter_active, 10'h000};
    4'hd: return {g.receiver_active, 10'h000};
    4'he: return {g.subcarrier_detected, 10'h000};
    default: return {g.test_bus_selected_bit, 10'h000};
  endcase
endfunction : atmp_ref

// ===== tb/atmp_top_chk.sv
// Concurrent checks of the aux selectors, register port and transmit test.
// Assumes a bind to atmp_top; shadows the selector and DAC registers.
`timescale 1ns/1ps
module atmp_top_chk
  import atmp_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          rst_n,
  input wire logic [3:0]    reg_addr,
  input wire logic [7:0]    reg_wdata,
  input wire logic          reg_write,
  input wire logic          reg_read,
  input wire logic [7:0]    reg_rdata,
  input wire atmp_analog_t  analog_in,
  input wire atmp_digital_t digital_in,
  input wire logic          aux_out_one,
  input wire logic          aux_out_one_oe_n,
  input wire logic          aux_one_dac_enable,
  input wire logic [7:0]    aux_one_dac_code,
  input wire logic          aux_out_two,
  input wire logic          aux_out_two_oe_n,
  input wire logic          aux_two_dac_enable,
  input wire logic [7:0]    aux_two_dac_code,
  input wire logic          tx_bit_valid
);
  `include "atmp_tb_ref.svh"
  logic [7:0]  sel_reg, dac1_reg, dac2_reg;
  logic [10:0] e1_reg, e2_reg;
  wire         ctrl_w = reg_write && reg_addr == 4'h3;
  wire         halt_w = ctrl_w && !reg_wdata[0];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sel_reg <= 8'h00;
      dac1_reg <= 8'h00;
      dac2_reg <= 8'h00;
      e1_reg <= 11'h200;
      e2_reg <= 11'h200;
    end else begin
      if (reg_write && reg_addr == 4'h0) sel_reg <= reg_wdata;
      if (reg_write && reg_addr == 4'h1) dac1_reg <= reg_wdata;
      if (reg_write && reg_addr == 4'h2) dac2_reg <= reg_wdata;
      e1_reg <= atmp_ref(sel_reg[7:4], dac1_reg, analog_in, digital_in);
      e2_reg <= atmp_ref(sel_reg[3:0], dac2_reg, analog_in, digital_in);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_go; ctrl_w && reg_wdata[0] && reg_wdata[2] && !tx_bit_valid; endsequence
  sequence s_arm; ctrl_w && reg_wdata[2:0] == 3'b001 && !tx_bit_valid; endsequence

  chk_aux_one_route: assert property ({aux_out_one_oe_n, aux_one_dac_enable,
    aux_one_dac_code} == e1_reg[9:0]) else $error("aux one route wrong");
  chk_aux_one_pin: assert property (!e1_reg[9] |-> aux_out_one == e1_reg[10])
    else $error("aux one pin wrong");
  chk_aux_two_route: assert property ({aux_out_two_oe_n, aux_two_dac_enable,
    aux_two_dac_code} == e2_reg[9:0]) else $error("aux two route wrong");
  chk_aux_two_pin: assert property (!e2_reg[9] |-> aux_out_two == e2_reg[10])
    else $error("aux two pin wrong");
  chk_tx_start: assert property (s_go |=> ##1 tx_bit_valid)
    else $error("transmit did not start");
  chk_enable_silent: assert property (s_arm |=> !tx_bit_valid [*2])
    else $error("enable alone started transmit");
  chk_tx_halt: assert property (halt_w |=> !tx_bit_valid)
    else $error("transmit did not stop");
  chk_tx_steady: assert property (tx_bit_valid && !halt_w |=> tx_bit_valid)
    else $error("transmit stopped on its own");
  chk_read_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_status_read: assert property (reg_read && reg_addr == 4'h5 |=>
    reg_rdata == {7'h00, $past(tx_bit_valid)}) else $error("status read wrong");
endmodule : atmp_top_chk

// ===== tb/atmp_aux_observer.sv
// Test-equipment view of the two aux pins with the recommended pull-down.
// Assumes oe_n low means the pin is driven digitally.
`timescale 1ns/1ps
module atmp_aux_observer (
  input  wire logic aux_out_one,
  input  wire logic aux_out_one_oe_n,
  input  wire logic aux_out_two,
  input  wire logic aux_out_two_oe_n,
  output logic      level_one,
  output logic      level_two
);
  // Released pin settles low
  assign level_one = aux_out_one_oe_n ? 1'b0 : aux_out_one;
  assign level_two = aux_out_two_oe_n ? 1'b0 : aux_out_two;
endmodule : atmp_aux_observer

// ===== tb/tb_atmp_top.sv
// Self-checking bench of the aux selectors and pseudo-random transmit test.
// Assumes the package, design, observer and checker are compiled first.
`timescale 1ns/1ps
module tb_atmp_top
  import atmp_pkg::*;
;
  `include "atmp_tb_ref.svh"
  logic          ref_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [3:0]    reg_addr = 4'h0;
  logic [7:0]    reg_wdata = 8'h00;
  logic          reg_write = 1'b0;
  logic          reg_read = 1'b0;
  logic [7:0]    reg_rdata, aux_one_dac_code, aux_two_dac_code;
  atmp_analog_t  analog_in = '0;
  atmp_digital_t digital_in = '0;
  logic          aux_out_one, aux_out_one_oe_n, aux_one_dac_enable, level_one;
  logic          aux_out_two, aux_out_two_oe_n, aux_two_dac_enable, level_two;
  logic          tx_bit, tx_bit_valid;
  int            err_total = 0;
  int            samples_checked = 0;
  int            cycles = 0;

  always #2.5 ref_clk = ~ref_clk;

  atmp_top u_atmp_top (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .analog_in(analog_in), .digital_in(digital_in), .aux_out_one(aux_out_one),
    .aux_out_one_oe_n(aux_out_one_oe_n), .aux_one_dac_enable(aux_one_dac_enable),
    .aux_one_dac_code(aux_one_dac_code), .aux_out_two(aux_out_two),
    .aux_out_two_oe_n(aux_out_two_oe_n), .aux_two_dac_enable(aux_two_dac_enable),
    .aux_two_dac_code(aux_two_dac_code), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid));
  atmp_aux_observer u_atmp_aux_observer (.aux_out_one(aux_out_one),
    .aux_out_one_oe_n(aux_out_one_oe_n), .aux_out_two(aux_out_two),
    .aux_out_two_oe_n(aux_out_two_oe_n), .level_one(level_one), .level_two(level_two));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic mux_case(input logic [3:0] s1, input logic [3:0] s2);
    logic [7:0]  d1, d2, v;
    logic [10:0] e1, e2;
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    @(posedge ref_clk);
    analog_in <= 40'({$urandom, $urandom});
    digital_in <= 6'($urandom);
    wr(4'h1, d1);
    wr(4'h2, d2);
    wr(4'h0, {s1, s2});
    @(posedge ref_clk);
    #1;
    e1 = atmp_ref(s1, d1, analog_in, digital_in);
    e2 = atmp_ref(s2, d2, analog_in, digital_in);
    check("aux_one", e1[9:0], {aux_out_one_oe_n, aux_one_dac_enable, aux_one_dac_code});
    check("aux_two", e2[9:0], {aux_out_two_oe_n, aux_two_dac_enable, aux_two_dac_code});
    check("pin1", e1[9] ? 1'b0 : e1[10], level_one);
    check("pin2", e2[9] ? 1'b0 : e2[10], level_two);
    rd(4'h0, v);
    check("config", {s1, s2}, v);
  endtask : mux_case

  task automatic prbs(input logic [7:0] fr, input logic lg);
    logic b[$];
    logic d[$];
    logic h[$];
    logic [7:0] v;
    logic p;
    int k, len, lag;
    len = lg ? 15 : 9;
    lag = lg ? 14 : 5;
    repeat (fr[6:4] * 8) h.push_back(1'b0);
    for (k = 7; k >= 0; k--) if (fr[3]) h.push_back(1'(`ATMP_SYNC_BYTE >> k));
    if (fr[2]) h.push_back(1'b1);
    wr(4'h4, fr);
    wr(4'h3, {5'h00, 1'b1, lg, 1'b1});
    @(posedge ref_clk);
    for (k = 0; k < 120; k++) begin
      #1;
      check("valid", 1'b1, tx_bit_valid);
      b.push_back(tx_bit);
      @(posedge ref_clk);
    end
    rd(4'h5, v);
    check("status", 8'h01, v);
    wr(4'h3, 8'h00);
    #1 check("stop", 1'b0, tx_bit_valid);
    for (k = 0; k < h.size(); k++) check("header", h[k], b[k]);
    k = h.size();
    while (k + 8 + fr[1] <= b.size()) begin
      p = fr[0];
      for (int j = 0; j < 8; j++) begin
        d.push_back(b[k + j]);
        p ^= b[k + j];
      end
      if (fr[1]) check("parity", p, b[k + 8]);
      k += 8 + fr[1];
    end
    for (k = len; k < d.size(); k++) check("sequence", d[k - lag] ^ d[k - len], d[k]);
  endtask : prbs

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    logic [7:0] v;
    void'($urandom(9));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 check("reset", 11'h600, {aux_out_one_oe_n, aux_out_two_oe_n, tx_bit_valid, reg_rdata});
    for (int i = 0; i < 16; i++) mux_case(4'(i), 4'(15 - i));
    repeat (20) mux_case(4'($urandom), 4'($urandom));
    rd(4'hf, v);
    check("unmapped", 8'h00, v);
    wr(4'h3, 8'h01);
    repeat (3) @(posedge ref_clk);
    #1 check("armed", 1'b0, tx_bit_valid);
    wr(4'h3, 8'h00);
    prbs(8'h00, 1'b0);
    prbs(8'h2f, 1'b1);
    prbs(8'h1a, 1'b0);
    conclude();
  end
endmodule : tb_atmp_top

bind atmp_top atmp_top_chk u_atmp_top_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .analog_in(analog_in), .digital_in(digital_in),
  .aux_out_one(aux_out_one), .aux_out_one_oe_n(aux_out_one_oe_n),
  .aux_one_dac_enable(aux_one_dac_enable), .aux_one_dac_code(aux_one_dac_code),
  .aux_out_two(aux_out_two), .aux_out_two_oe_n(aux_out_two_oe_n),
  .aux_two_dac_enable(aux_two_dac_enable), .aux_two_dac_code(aux_two_dac_code),
  .tx_bit_valid(tx_bit_valid));
